// *** chan_pkg.sv ***
package chan_pkg;

  localparam int POS_W   = 32;
  localparam int CAUSE_W = 16;

  localparam logic [CAUSE_W-1:0] CAUSE_NONE      = 16'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_REF_RANGE = 16'h0001;
  localparam logic [CAUSE_W-1:0] CAUSE_HW_FAULT  = 16'h0002;
  localparam logic [CAUSE_W-1:0] CAUSE_CMD_FAULT = 16'h0003;

  localparam logic [POS_W-1:0] REF0_RESET = 32'h00000000;
  localparam logic [POS_W-1:0] REF1_RESET = 32'h0000000a;

  typedef enum logic [1:0] {
    OUT_OFF,
    OUT_CPU,
    OUT_SET_UNTIL_CMP,
    OUT_COMPARE
  } out_mode_t;

  typedef struct packed {
    logic cmp_hit_0;
    logic cmp_hit_1;
    logic zero_reached_flag;
    logic upper_range_exceeded;
    logic lower_range_exceeded;
  } event_flags_t;

  typedef struct packed {
    logic [POS_W-1:0] ref0_active_pos;
    logic [POS_W-1:0] ref1_active_pos;
    logic [POS_W-1:0] ref0_active_meas;
    logic [POS_W-1:0] ref1_active_meas;
  } active_refs_t;

endpackage

// *** sync_edge.sv ***
`timescale 1ns/10ps
module sync_edge #(
  parameter bit PIN = 1'b0
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic cur;
  logic prev;

  always_ff @(posedge CLK) begin
    if (RST) begin
      meta <= 1'b0;
      cur  <= 1'b0;
    end else begin
      meta <= din;
      cur  <= PIN ? meta : din;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) prev <= 1'b0;
    else     prev <= cur;
  end

  // edge from present sample against last cycle's
  assign level = cur;
  assign rise  = cur & ~prev;
  assign fall  = ~cur & prev;
endmodule

// *** dout_ctrl.sv ***
`timescale 1ns/10ps
module dout_ctrl
  import chan_pkg::*;
(
  input  wire logic      CLK,
  input  wire logic      RST,
  input  out_mode_t      mode,
  input  wire logic      override,
  input  wire logic      set_level,
  input  wire logic      set_fall,
  input  wire logic      pos_match,
  input  wire logic      cmp_state,
  output logic           dout,
  output logic           changed
);
  logic next_dout;

  always_comb begin
    next_dout = dout;
    if (override || mode == OUT_CPU) begin
      next_dout = set_level;
    end else begin
      case (mode)
        OUT_SET_UNTIL_CMP: begin
          if (set_fall)       next_dout = ~dout;
          else if (pos_match) next_dout = 1'b0;
        end
        OUT_COMPARE: next_dout = cmp_state;
        default:     next_dout = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) dout <= 1'b0;
    else     dout <= next_dout;
  end

  // change of state caused by the compare path only
  assign changed = ~override && mode == OUT_COMPARE && next_dout != dout;
endmodule

// *** ssi_channel_control_status_if.sv ***
`timescale 1ns/10ps
module ssi_channel_control_status_if
  import chan_pkg::*;
#(
  parameter int W            = chan_pkg::POS_W,
  parameter bit ACK_LEVEL    = 1'b1,
  parameter bit CAPTURE_RISE = 1'b1
) (
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic                       REF0_UPDATE_REQUEST,
  input  wire logic                       REF1_UPDATE_REQUEST,
  input  wire logic [W-1:0]               REF0_STAGED_POS,
  input  wire logic [W-1:0]               REF1_STAGED_POS,
  input  wire logic [W-1:0]               REF0_STAGED_MEAS,
  input  wire logic [W-1:0]               REF1_STAGED_MEAS,
  output logic                            REF0_UPDATE_BUSY,
  output logic                            REF1_UPDATE_BUSY,
  output chan_pkg::active_refs_t          ACTIVE_REFS,
  input  wire logic                       COMPARE_SOURCE_IS_MEAS,
  output logic                            COMPARE_SOURCE_STATUS,
  input  wire logic signed [W-1:0]        CURRENT_POSITION,
  input  wire logic signed [W-1:0]        CURRENT_MEASUREMENT,
  input  wire logic signed [W-1:0]        POS_LIMIT_HIGH,
  input  wire logic signed [W-1:0]        POS_LIMIT_LOW,
  input  wire logic                       EVENT_ACKNOWLEDGE,
  output chan_pkg::event_flags_t          EVENT_FLAGS,
  input  wire logic                       INPUT0_PIN,
  input  wire logic                       INPUT1_PIN,
  output logic                            INPUT0_LEVEL,
  output logic                            INPUT1_LEVEL,
  input  chan_pkg::out_mode_t             OUT0_MODE,
  input  chan_pkg::out_mode_t             OUT1_MODE,
  input  wire logic                       OUTPUT0_MANUAL_OVERRIDE,
  input  wire logic                       OUTPUT1_MANUAL_OVERRIDE,
  input  wire logic                       OUTPUT0_SET_CMD,
  input  wire logic                       OUTPUT1_SET_CMD,
  output logic                            OUTPUT0,
  output logic                            OUTPUT1,
  input  wire logic                       HW_FAULT,
  input  wire logic                       ERROR_ACKNOWLEDGE,
  output logic                            ERROR_FLAG,
  output logic [chan_pkg::CAUSE_W-1:0]    ERROR_CAUSE_CODE,
  input  wire logic                       CAPTURE_ON_INPUT1,
  input  wire logic                       CAPTURE_ARM,
  output logic                            CAPTURE_VALID_FLAG,
  output logic [W-1:0]                    LATCHED_CAPTURE
);
  import chan_pkg::*;

  logic ev_ack_rise, err_ack_lvl, err_ack_rise, cap_arm_fall, cap_arm_lvl;
  logic in0_rise, in0_fall, in1_rise, in1_fall;
  logic set0_lvl, set0_fall, set1_lvl, set1_fall;
  logic armed, cap_edge;
  logic signed [W-1:0] prev_pos;
  logic signed [W-1:0] cmp_val, ref0_sel, ref1_sel;
  logic ack_now, fault_now;
  logic [CAUSE_W-1:0] fault_code;
  logic err_acked;
  logic ch0, ch1;
  logic ref_fault;

  sync_edge #(.PIN(1'b0)) u_evack (.CLK(CLK), .RST(RST), .din(EVENT_ACKNOWLEDGE),
    .level(), .rise(ev_ack_rise), .fall());
  sync_edge #(.PIN(1'b0)) u_erack (.CLK(CLK), .RST(RST), .din(ERROR_ACKNOWLEDGE),
    .level(err_ack_lvl), .rise(err_ack_rise), .fall());
  sync_edge #(.PIN(1'b0)) u_cap (.CLK(CLK), .RST(RST), .din(CAPTURE_ARM),
    .level(cap_arm_lvl), .rise(), .fall(cap_arm_fall));
  sync_edge #(.PIN(1'b1)) u_in0 (.CLK(CLK), .RST(RST), .din(INPUT0_PIN),
    .level(INPUT0_LEVEL), .rise(in0_rise), .fall(in0_fall));
  sync_edge #(.PIN(1'b1)) u_in1 (.CLK(CLK), .RST(RST), .din(INPUT1_PIN),
    .level(INPUT1_LEVEL), .rise(in1_rise), .fall(in1_fall));
  sync_edge #(.PIN(1'b0)) u_set0 (.CLK(CLK), .RST(RST), .din(OUTPUT0_SET_CMD),
    .level(set0_lvl), .rise(), .fall(set0_fall));
  sync_edge #(.PIN(1'b0)) u_set1 (.CLK(CLK), .RST(RST), .din(OUTPUT1_SET_CMD),
    .level(set1_lvl), .rise(), .fall(set1_fall));

  assign COMPARE_SOURCE_STATUS = COMPARE_SOURCE_IS_MEAS;

  // reference update: apply staged pair, then drop busy
  always_ff @(posedge CLK) begin
    if (RST) begin
      ACTIVE_REFS      <= '{REF0_RESET, REF1_RESET, REF0_RESET, REF1_RESET};
      REF0_UPDATE_BUSY <= 1'b0;
      REF1_UPDATE_BUSY <= 1'b0;
    end else begin
      REF0_UPDATE_BUSY <= REF0_UPDATE_REQUEST & ~REF0_UPDATE_BUSY;
      REF1_UPDATE_BUSY <= REF1_UPDATE_REQUEST & ~REF1_UPDATE_BUSY;
      if (REF0_UPDATE_REQUEST && !REF0_UPDATE_BUSY) begin
        ACTIVE_REFS.ref0_active_pos  <= REF0_STAGED_POS;
        ACTIVE_REFS.ref0_active_meas <= REF0_STAGED_MEAS;
      end
      if (REF1_UPDATE_REQUEST && !REF1_UPDATE_BUSY) begin
        ACTIVE_REFS.ref1_active_pos  <= REF1_STAGED_POS;
        ACTIVE_REFS.ref1_active_meas <= REF1_STAGED_MEAS;
      end
    end
  end

  // reference 0 above reference 1 is a reference range fault
  assign ref_fault = (REF0_UPDATE_REQUEST && !REF0_UPDATE_BUSY &&
                      $signed(REF0_STAGED_POS) > $signed(ACTIVE_REFS.ref1_active_pos)) ||
                     (REF1_UPDATE_REQUEST && !REF1_UPDATE_BUSY &&
                      $signed(REF1_STAGED_POS) < $signed(ACTIVE_REFS.ref0_active_pos));

  // source selection
  always_comb begin
    if (COMPARE_SOURCE_IS_MEAS) begin
      cmp_val  = CURRENT_MEASUREMENT;
      ref0_sel = ACTIVE_REFS.ref0_active_meas;
      ref1_sel = ACTIVE_REFS.ref1_active_meas;
    end else begin
      cmp_val  = CURRENT_POSITION;
      ref0_sel = ACTIVE_REFS.ref0_active_pos;
      ref1_sel = ACTIVE_REFS.ref1_active_pos;
    end
  end

  dout_ctrl u_dq0 (.CLK(CLK), .RST(RST), .mode(OUT0_MODE), .override(OUTPUT0_MANUAL_OVERRIDE),
    .set_level(set0_lvl), .set_fall(set0_fall), .pos_match(cmp_val == ref0_sel),
    .cmp_state(cmp_val >= ref0_sel && cmp_val <= ref1_sel), .dout(OUTPUT0), .changed(ch0));
  dout_ctrl u_dq1 (.CLK(CLK), .RST(RST), .mode(OUT1_MODE), .override(OUTPUT1_MANUAL_OVERRIDE),
    .set_level(set1_lvl), .set_fall(set1_fall), .pos_match(cmp_val == ref1_sel),
    .cmp_state(cmp_val >= ref1_sel), .dout(OUTPUT1), .changed(ch1));

  always_ff @(posedge CLK) begin
    if (RST) prev_pos <= '0;
    else     prev_pos <= CURRENT_POSITION;
  end

  // sticky events: set wins over acknowledge
  always_ff @(posedge CLK) begin
    if (RST) begin
      EVENT_FLAGS <= '0;
    end else begin
      EVENT_FLAGS.cmp_hit_0 <= ch0 | (EVENT_FLAGS.cmp_hit_0 & ~ev_ack_rise);
      EVENT_FLAGS.cmp_hit_1 <= ch1 | (EVENT_FLAGS.cmp_hit_1 & ~ev_ack_rise);
      EVENT_FLAGS.zero_reached_flag <= (CURRENT_POSITION == '0 ||
        (CURRENT_POSITION[W-1] != prev_pos[W-1] && prev_pos != CURRENT_POSITION)) |
        (EVENT_FLAGS.zero_reached_flag & ~ev_ack_rise);
      EVENT_FLAGS.upper_range_exceeded <= (CURRENT_POSITION > POS_LIMIT_HIGH) |
        (EVENT_FLAGS.upper_range_exceeded & ~ev_ack_rise);
      EVENT_FLAGS.lower_range_exceeded <= (CURRENT_POSITION < POS_LIMIT_LOW) |
        (EVENT_FLAGS.lower_range_exceeded & ~ev_ack_rise);
    end
  end

  // capture
  assign cap_edge = CAPTURE_ON_INPUT1 ? (CAPTURE_RISE ? in1_rise : in1_fall)
                                      : (CAPTURE_RISE ? in0_rise : in0_fall);

  always_ff @(posedge CLK) begin
    if (RST) begin
      armed              <= 1'b0;
      CAPTURE_VALID_FLAG <= 1'b0;
    end else if (cap_arm_fall) begin
      armed              <= 1'b0;
      CAPTURE_VALID_FLAG <= 1'b0;
    end else begin
      armed <= cap_arm_lvl & ~(armed & cap_edge);
      if (armed && cap_edge) CAPTURE_VALID_FLAG <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST)                     LATCHED_CAPTURE <= '0;
    else if (armed && cap_edge)  LATCHED_CAPTURE <= CURRENT_POSITION;
  end

  // error handling
  assign ack_now   = ACK_LEVEL ? err_ack_lvl : err_ack_rise;
  assign fault_now = HW_FAULT | ref_fault;
  assign fault_code = HW_FAULT ? CAUSE_HW_FAULT : CAUSE_REF_RANGE;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ERROR_FLAG       <= 1'b0;
      ERROR_CAUSE_CODE <= CAUSE_NONE;
      err_acked        <= 1'b0;
    end else if (!ERROR_FLAG) begin
      if (fault_now) begin
        ERROR_FLAG       <= 1'b1;
        ERROR_CAUSE_CODE <= fault_code;
        err_acked        <= 1'b0;
      end
    end else begin
      if (ack_now) err_acked <= 1'b1;
      if ((err_acked || ack_now) && !HW_FAULT) begin
        ERROR_FLAG       <= 1'b0;
        ERROR_CAUSE_CODE <= CAUSE_NONE;
      end
    end
  end

  property p_evack_clears;
    @(posedge CLK) disable iff (RST)
      ev_ack_rise && !ch0 |=> !EVENT_FLAGS.cmp_hit_0;
  endproperty
  a_evack_clears: assert property (p_evack_clears) else $error("hit0 not cleared");

  property p_cap_fall;
    @(posedge CLK) disable iff (RST) cap_arm_fall |=> !CAPTURE_VALID_FLAG && !armed;
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("capture not withdrawn");

  sequence s_capture;
    armed && cap_edge && !cap_arm_fall;
  endsequence
  property p_capture;
    @(posedge CLK) disable iff (RST)
      s_capture |=> CAPTURE_VALID_FLAG && LATCHED_CAPTURE == $past(CURRENT_POSITION);
  endproperty
  a_capture: assert property (p_capture) else $error("capture not taken");

  property p_hold;
    @(posedge CLK) disable iff (RST) !(armed && cap_edge) |=> $stable(LATCHED_CAPTURE);
  endproperty
  a_hold: assert property (p_hold) else $error("capture value moved");

  property p_update;
    @(posedge CLK) disable iff (RST)
      REF0_UPDATE_REQUEST && !REF0_UPDATE_BUSY |=>
        ACTIVE_REFS.ref0_active_pos == $past(REF0_STAGED_POS) ##1 !REF0_UPDATE_BUSY;
  endproperty
  a_update: assert property (p_update) else $error("reference 0 not applied");

  property p_err_hold;
    @(posedge CLK) disable iff (RST)
      ERROR_FLAG && !ack_now && !err_acked |=> ERROR_FLAG && $stable(ERROR_CAUSE_CODE);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error replaced before ack");

  property p_err_raise;
    @(posedge CLK) disable iff (RST) !ERROR_FLAG && fault_now |=> ERROR_FLAG;
  endproperty
  a_err_raise: assert property (p_err_raise) else $error("fault not flagged");

  property p_err_stay;
    @(posedge CLK) disable iff (RST) ERROR_FLAG && HW_FAULT |=> ERROR_FLAG;
  endproperty
  a_err_stay: assert property (p_err_stay) else $error("error cleared with fault");

  property p_follow;
    @(posedge CLK) disable iff (RST) OUTPUT1_MANUAL_OVERRIDE |=> OUTPUT1 == $past(set1_lvl);
  endproperty
  a_follow: assert property (p_follow) else $error("output 1 not following");
endmodule

// *** ref_host_model.sv ***
`timescale 1ns/10ps
module ref_host_model
  import chan_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             go,
  input  wire logic             sel,
  input  wire logic [POS_W-1:0] pos_val,
  input  wire logic [POS_W-1:0] meas_val,
  input  wire logic             busy0,
  input  wire logic             busy1,
  output logic                  req0,
  output logic                  req1,
  output logic [POS_W-1:0]      st0_pos,
  output logic [POS_W-1:0]      st1_pos,
  output logic [POS_W-1:0]      st0_meas,
  output logic [POS_W-1:0]      st1_meas,
  output logic                  done
);
  logic [1:0] step;

  initial begin
    step = 2'h0;
    req0 = 1'b0;
    req1 = 1'b0;
    done = 1'b0;
    {st0_pos, st1_pos, st0_meas, st1_meas} = '0;
  end

  // one change job at a time; staged value written a cycle before the request
  always @(posedge clk) begin
    done <= 1'b0;
    case (step)
      2'h0: if (go) step <= 2'h1;
      2'h1: if (!busy0 && !busy1 && !req0 && !req1) begin
        step <= 2'h2;
        if (sel) begin
          st1_pos  <= pos_val;
          st1_meas <= meas_val;
        end else begin
          st0_pos  <= pos_val;
          st0_meas <= meas_val;
        end
      end
      2'h2: begin
        req0 <= !sel;
        req1 <= sel;
        step <= 2'h3;
      end
      default: if (sel ? busy1 : busy0) begin
        req0 <= 1'b0;
        req1 <= 1'b0;
        done <= 1'b1;
        step <= 2'h0;
      end
    endcase
  end
endmodule

// *** ssi_channel_control_status_if_test.sv ***
`timescale 1ns/10ps
module ssi_channel_control_status_if_test;
  import chan_pkg::*;
  logic CLK, RST, REF0_UPDATE_REQUEST, REF1_UPDATE_REQUEST, REF0_UPDATE_BUSY, REF1_UPDATE_BUSY;
  logic [31:0] REF0_STAGED_POS, REF1_STAGED_POS, REF0_STAGED_MEAS, REF1_STAGED_MEAS, pv, mv;
  logic signed [31:0] CURRENT_POSITION, CURRENT_MEASUREMENT, POS_LIMIT_HIGH, POS_LIMIT_LOW;
  active_refs_t ACTIVE_REFS;
  event_flags_t EVENT_FLAGS;
  out_mode_t OUT0_MODE, OUT1_MODE;
  logic COMPARE_SOURCE_IS_MEAS, COMPARE_SOURCE_STATUS, EVENT_ACKNOWLEDGE, INPUT0_PIN, INPUT1_PIN;
  logic INPUT0_LEVEL, INPUT1_LEVEL, OUTPUT0_MANUAL_OVERRIDE, OUTPUT1_MANUAL_OVERRIDE;
  logic OUTPUT0_SET_CMD, OUTPUT1_SET_CMD, OUTPUT0, OUTPUT1, HW_FAULT, ERROR_ACKNOWLEDGE;
  logic ERROR_FLAG, CAPTURE_ON_INPUT1, CAPTURE_ARM, CAPTURE_VALID_FLAG, go, sel, done;
  logic [15:0] ERROR_CAUSE_CODE;
  logic [31:0] LATCHED_CAPTURE;
  int fail_count = 0;
  int cmp_count = 0;

  ssi_channel_control_status_if u_ssi_channel_control_status_if (
    .CLK, .RST, .REF0_UPDATE_REQUEST, .REF1_UPDATE_REQUEST, .REF0_STAGED_POS, .REF1_STAGED_POS,
    .REF0_STAGED_MEAS, .REF1_STAGED_MEAS, .REF0_UPDATE_BUSY, .REF1_UPDATE_BUSY, .ACTIVE_REFS,
    .COMPARE_SOURCE_IS_MEAS, .COMPARE_SOURCE_STATUS, .CURRENT_POSITION, .CURRENT_MEASUREMENT,
    .POS_LIMIT_HIGH, .POS_LIMIT_LOW, .EVENT_ACKNOWLEDGE, .EVENT_FLAGS, .INPUT0_PIN, .INPUT1_PIN,
    .INPUT0_LEVEL, .INPUT1_LEVEL, .OUT0_MODE, .OUT1_MODE, .OUTPUT0_MANUAL_OVERRIDE,
    .OUTPUT1_MANUAL_OVERRIDE, .OUTPUT0_SET_CMD, .OUTPUT1_SET_CMD, .OUTPUT0, .OUTPUT1, .HW_FAULT,
    .ERROR_ACKNOWLEDGE, .ERROR_FLAG, .ERROR_CAUSE_CODE, .CAPTURE_ON_INPUT1, .CAPTURE_ARM,
    .CAPTURE_VALID_FLAG, .LATCHED_CAPTURE);

  ref_host_model u_ref_host_model (
    .clk(CLK), .go, .sel, .pos_val(pv), .meas_val(mv), .busy0(REF0_UPDATE_BUSY),
    .busy1(REF1_UPDATE_BUSY), .req0(REF0_UPDATE_REQUEST), .req1(REF1_UPDATE_REQUEST),
    .st0_pos(REF0_STAGED_POS), .st1_pos(REF1_STAGED_POS), .st0_meas(REF0_STAGED_MEAS),
    .st1_meas(REF1_STAGED_MEAS), .done);

  always #50 CLK = ~CLK;

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic t_ref(input logic s, input logic [31:0] p, input logic [31:0] m);
    go <= 1'b1;
    sel <= s;
    pv <= p;
    mv <= m;
    tick(1);
    go <= 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) tick(1);
    tick(2);
    chk(s ? ACTIVE_REFS.ref1_active_pos : ACTIVE_REFS.ref0_active_pos, p);
    chk(s ? ACTIVE_REFS.ref1_active_meas : ACTIVE_REFS.ref0_active_meas, m);
    chk({REF0_UPDATE_BUSY, REF1_UPDATE_BUSY}, 0);
  endtask

  task automatic t_mode();
    OUT0_MODE <= OUT_COMPARE;
    CURRENT_POSITION <= 5;
    CURRENT_MEASUREMENT <= 50;
    tick(6);
    chk({COMPARE_SOURCE_STATUS, OUTPUT0, EVENT_FLAGS.cmp_hit_0}, 3'b011);
    COMPARE_SOURCE_IS_MEAS <= 1'b1;
    tick(6);
    chk({COMPARE_SOURCE_STATUS, OUTPUT0}, 2'b11);
    CURRENT_MEASUREMENT <= 500;
    tick(6);
    chk(OUTPUT0, 0);
  endtask

  task automatic t_evt();
    OUT1_MODE <= OUT_COMPARE;
    CURRENT_POSITION <= 2000;
    tick(3);
    CURRENT_POSITION <= -2000;
    tick(3);
    CURRENT_POSITION <= 5;
    tick(6);
    chk(EVENT_FLAGS, 5'h1f);
    EVENT_ACKNOWLEDGE <= 1'b1;
    for (int i = 0; i < 8 && EVENT_FLAGS !== 5'h00; i++) tick(1);
    chk(EVENT_FLAGS, 0);
    EVENT_ACKNOWLEDGE <= 1'b0;
    tick(1);
  endtask

  task automatic t_io();
    INPUT0_PIN <= 1'b1;
    tick(4);
    chk({INPUT0_LEVEL, INPUT1_LEVEL}, 2'b10);
    OUT1_MODE <= OUT_CPU;
    OUTPUT1_SET_CMD <= 1'b1;
    tick(4);
    chk(OUTPUT1, 1);
    OUTPUT1_SET_CMD <= 1'b0;
    OUT1_MODE <= OUT_OFF;
    OUTPUT1_MANUAL_OVERRIDE <= 1'b1;
    tick(4);
    chk(OUTPUT1, 0);
    OUTPUT1_SET_CMD <= 1'b1;
    tick(4);
    chk(OUTPUT1, 1);
    OUTPUT1_MANUAL_OVERRIDE <= 1'b0;
    OUT1_MODE <= OUT_SET_UNTIL_CMP;
    tick(4);
    chk(OUTPUT1, 1);
    for (int k = 0; k < 2; k++) begin
      OUTPUT1_SET_CMD <= 1'b0;
      tick(4);
      chk(OUTPUT1, k != 0);
      OUTPUT1_SET_CMD <= 1'b1;
      tick(4);
    end
    CURRENT_MEASUREMENT <= 100;
    tick(4);
    chk(OUTPUT1, 0);
  endtask

  task automatic t_err();
    HW_FAULT <= 1'b1;
    tick(4);
    chk({ERROR_FLAG, ERROR_CAUSE_CODE}, {1'b1, CAUSE_HW_FAULT});
    HW_FAULT <= 1'b0;
    tick(4);
    chk(ERROR_FLAG, 1);
    HW_FAULT <= 1'b1;
    ERROR_ACKNOWLEDGE <= 1'b1;
    tick(4);
    chk(ERROR_FLAG, 1);
    HW_FAULT <= 1'b0;
    tick(4);
    chk(ERROR_FLAG, 0);
    ERROR_ACKNOWLEDGE <= 1'b0;
  endtask

  task automatic t_cap();
    CAPTURE_ON_INPUT1 <= 1'b1;
    CAPTURE_ARM <= 1'b1;
    CURRENT_POSITION <= 77;
    tick(6);
    INPUT1_PIN <= 1'b1;
    tick(6);
    chk({CAPTURE_VALID_FLAG, LATCHED_CAPTURE}, {1'b1, 32'h4d});
    CAPTURE_ARM <= 1'b0;
    CURRENT_POSITION <= 88;
    INPUT1_PIN <= 1'b0;
    tick(6);
    INPUT1_PIN <= 1'b1;
    tick(6);
    chk({CAPTURE_VALID_FLAG, LATCHED_CAPTURE}, {1'b0, 32'h4d});
  endtask

  initial begin
    #300000;
    fail_count++;
    results();
  end

  initial begin
    {CLK, COMPARE_SOURCE_IS_MEAS, EVENT_ACKNOWLEDGE, INPUT0_PIN, INPUT1_PIN, HW_FAULT} = '0;
    {OUTPUT0_MANUAL_OVERRIDE, OUTPUT1_MANUAL_OVERRIDE, OUTPUT0_SET_CMD, OUTPUT1_SET_CMD} = '0;
    {ERROR_ACKNOWLEDGE, CAPTURE_ON_INPUT1, CAPTURE_ARM, go, sel, pv, mv} = '0;
    {CURRENT_POSITION, CURRENT_MEASUREMENT} = '0;
    POS_LIMIT_HIGH = 1000;
    POS_LIMIT_LOW = -1000;
    OUT0_MODE = OUT_OFF;
    OUT1_MODE = OUT_OFF;
    RST = 1'b1;
    tick(4);
    RST <= 1'b0;
    tick(1);
    chk(ACTIVE_REFS, {REF0_RESET, REF1_RESET, REF0_RESET, REF1_RESET});
    chk({ERROR_FLAG, EVENT_FLAGS, CAPTURE_VALID_FLAG, OUTPUT0, OUTPUT1}, 0);
    t_ref(1'b0, 32'h3, 32'h7);
    t_ref(1'b1, 32'h14, 32'h64);
    t_mode();
    t_evt();
    t_io();
    t_err();
    t_cap();
    results();
  end
endmodule
